// [rtl/dcff_params.svh]
// constants for the flag and replay fifo block
`ifndef DCFF_PARAMS_SVH
`define DCFF_PARAMS_SVH
`define DCFF_DATA_W 36
`define DCFF_AW 19
`define DCFF_PTR_W 20
`define DCFF_DEPTH_STD 20'h80000
`define DCFF_DEPTH_FALL_THROUGH_MODE 20'h80001
`define DCFF_ONE 20'h00001
`define DCFF_ZERO 20'h00000
`define DCFF_APB_AW 8
`define DCFF_OFS_CTRL 8'h00
`define DCFF_OFS_PAE 8'h04
`define DCFF_OFS_PAF 8'h08
`define DCFF_OFS_STATUS 8'h0c
`define DCFF_OFS_LEVEL 8'h10
`define DCFF_CTRL_ASYNC_WR 0
`define DCFF_CTRL_ASYNC_RD 1
`define DCFF_CTRL_MARK_SET 2
`define DCFF_CTRL_MARK_CLR 3
`define DCFF_PAE_RST 20'h003ff
`define DCFF_PAF_RST 20'h003ff
`define DCFF_FLAGS_RST 6'h25
`endif

// [rtl/dcff_pkg.sv]
// types shared by the flag and replay fifo block
package dcff_pkg;
  typedef enum logic {DCFF_RUN, DCFF_REPLAY} dcff_state_type;
  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic out_ready_n;
    logic in_ready_n;
    logic almost_empty_n;
    logic almost_full_n;
  } dcff_flags_type;
  typedef struct packed {
    logic async_rd;
    logic async_wr;
  } dcff_ctrl_type;
endpackage

// [rtl/dcff_ram.sv]
// storage array of the fifo with registered read port
`timescale 1ns/1ps
`include "dcff_params.svh"
module dcff_ram (
  input wire logic clk,
  input wire logic we,
  input wire logic [`DCFF_AW-1:0] waddr,
  input wire logic [`DCFF_DATA_W-1:0] wdata,
  input wire logic re,
  input wire logic [`DCFF_AW-1:0] raddr,
  output logic [`DCFF_DATA_W-1:0] q
);
  logic [`DCFF_DATA_W-1:0] mem [0:(1<<`DCFF_AW)-1];

  // no reset on the array; q only means something once a read happened
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      q <= mem[raddr];
    end
  end
endmodule // dcff_ram

// [rtl/dcff_top.sv]
// fifo with mark and replay, programmable flags and apb control
`timescale 1ns/1ps
`include "dcff_params.svh"
module dcff_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`DCFF_APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`DCFF_DATA_W-1:0] wr_data,
  input wire logic write_enable_n,
  input wire logic write_select_n,
  input wire logic read_enable_n,
  input wire logic read_select_n,
  output logic [`DCFF_DATA_W-1:0] rd_data,
  input wire logic replay_request_n,
  input wire logic fall_through_mode,
  input wire logic flag_timing_select,
  output dcff_pkg::dcff_flags_type flags
);
  localparam int PW = `DCFF_PTR_W;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return p + `DCFF_ONE;
  endfunction

  function automatic logic fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  // returns {almost_empty_n, almost_full_n} for a word count
  function automatic logic [1:0] level_flags(input logic [PW-1:0] total,
      input logic [PW-1:0] depth, input logic [PW-1:0] pae_ofs,
      input logic [PW-1:0] paf_ofs);
    logic ae_n;
    logic af_n;
    ae_n = total > pae_ofs;
    af_n = total < (depth - paf_ofs);
    return {ae_n, af_n};
  endfunction

  function automatic logic mapped(input logic [`DCFF_APB_AW-1:0] a);
    return a == `DCFF_OFS_CTRL || a == `DCFF_OFS_PAE ||
      a == `DCFF_OFS_PAF || a == `DCFF_OFS_STATUS ||
      a == `DCFF_OFS_LEVEL;
  endfunction

  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] wptr_next;
  logic [PW-1:0] rptr_reg;
  logic [PW-1:0] rptr_next;
  logic [PW-1:0] mark_ptr_reg;
  logic [PW-1:0] mark_ptr_next;
  logic mark_valid_reg;
  logic mark_valid_next;
  logic out_valid_reg;
  logic out_valid_next;
  dcff_pkg::dcff_state_type state_reg;
  dcff_pkg::dcff_state_type state_next;
  logic sync_flags_reg;
  logic sync_flags_next;
  logic fall_through_mode_reg;
  logic fall_through_mode_next;
  logic cap_done_reg;
  logic cap_done_next;
  logic wen_prev_reg;
  logic ren_prev_reg;
  logic rt_prev_reg;
  dcff_pkg::dcff_ctrl_type ctrl_reg;
  dcff_pkg::dcff_ctrl_type ctrl_next;
  logic [PW-1:0] pae_ofs_reg;
  logic [PW-1:0] pae_ofs_next;
  logic [PW-1:0] paf_ofs_reg;
  logic [PW-1:0] paf_ofs_next;
  dcff_pkg::dcff_flags_type flags_reg;
  dcff_pkg::dcff_flags_type flags_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  logic [PW-1:0] count;
  logic [PW-1:0] count_next;
  logic [PW-1:0] total;
  logic [PW-1:0] total_next;
  logic [PW-1:0] depth;
  logic full_now;
  logic full_next;
  logic wstrobe;
  logic rstrobe;
  logic async_rd_eff;
  logic do_write;
  logic do_read;
  logic ff_load;
  logic ff_drain;
  logic ram_re;
  logic replay_go;
  logic run_ok;
  logic apb_wr;
  logic mark_set;
  logic mark_clr;
  logic [1:0] lvl_now;
  logic [1:0] lvl_next;
  logic [1:0] lvl_sel;

  // apb write side and mode capture
  always_comb begin
    apb_wr = psel & penable & pwrite;
    ctrl_next = ctrl_reg;
    pae_ofs_next = pae_ofs_reg;
    paf_ofs_next = paf_ofs_reg;
    mark_set = 1'b0;
    mark_clr = 1'b0;
    if (apb_wr) begin
      case (paddr)
        `DCFF_OFS_CTRL: begin
          ctrl_next.async_wr = pwdata[`DCFF_CTRL_ASYNC_WR];
          ctrl_next.async_rd = pwdata[`DCFF_CTRL_ASYNC_RD];
          mark_set = pwdata[`DCFF_CTRL_MARK_SET];
          mark_clr = pwdata[`DCFF_CTRL_MARK_CLR];
        end
        `DCFF_OFS_PAE: pae_ofs_next = pwdata[PW-1:0];
        `DCFF_OFS_PAF: paf_ofs_next = pwdata[PW-1:0];
        default: begin
        end
      endcase
    end
    // modes are caught on the first edge after reset release
    cap_done_next = 1'b1;
    sync_flags_next = cap_done_reg ? sync_flags_reg : flag_timing_select;
    fall_through_mode_next = cap_done_reg ? fall_through_mode_reg : fall_through_mode;
  end

  // datapath pointers, replay and flags
  always_comb begin
    run_ok = cap_done_reg && state_reg == dcff_pkg::DCFF_RUN;
    async_rd_eff = ctrl_reg.async_rd & ~fall_through_mode_reg;
    depth = fall_through_mode_reg ? `DCFF_DEPTH_FALL_THROUGH_MODE : `DCFF_DEPTH_STD;
    count = wptr_reg - rptr_reg;
    total = count + {{(PW-1){1'b0}}, fall_through_mode_reg & out_valid_reg};
    // marked words count as occupied until the mark is dropped
    full_now = count == `DCFF_DEPTH_STD ||
      (mark_valid_reg && (wptr_reg - mark_ptr_reg) == `DCFF_DEPTH_STD);
    wstrobe = ctrl_reg.async_wr ? fell(wen_prev_reg, write_enable_n)
                                : ~write_enable_n;
    wstrobe = wstrobe & ~write_select_n;
    rstrobe = async_rd_eff ? fell(ren_prev_reg, read_enable_n)
                           : ~read_enable_n;
    rstrobe = rstrobe & ~read_select_n;
    replay_go = run_ok && mark_valid_reg &&
      fell(rt_prev_reg, replay_request_n);
    do_write = cap_done_reg && wstrobe && !full_now;
    do_read = !fall_through_mode_reg && run_ok && !replay_go && rstrobe &&
      count != `DCFF_ZERO;
    // first word falls through with no enables; later ones need both
    ff_load = fall_through_mode_reg && run_ok && !replay_go && count != `DCFF_ZERO &&
      (!out_valid_reg || rstrobe);
    ff_drain = fall_through_mode_reg && run_ok && out_valid_reg && rstrobe &&
      count == `DCFF_ZERO;
    ram_re = do_read | ff_load;
    wptr_next = do_write ? ptr_inc(wptr_reg) : wptr_reg;
    rptr_next = rptr_reg;
    out_valid_next = out_valid_reg;
    state_next = state_reg;
    if (replay_go) begin
      rptr_next = mark_ptr_reg;
      out_valid_next = 1'b0;
      state_next = dcff_pkg::DCFF_REPLAY;
    end else begin
      if (ram_re) begin
        rptr_next = ptr_inc(rptr_reg);
      end
      if (ff_load) begin
        out_valid_next = 1'b1;
      end else if (ff_drain) begin
        out_valid_next = 1'b0;
      end
      state_next = dcff_pkg::DCFF_RUN;
    end
    mark_valid_next = mark_valid_reg;
    mark_ptr_next = mark_ptr_reg;
    if (mark_clr) begin
      mark_valid_next = 1'b0;
    end
    // a set in the same write beats the clear
    if (mark_set) begin
      mark_valid_next = 1'b1;
      mark_ptr_next = rptr_reg -
        {{(PW-1){1'b0}}, fall_through_mode_reg & out_valid_reg};
    end
    count_next = wptr_next - rptr_next;
    total_next = count_next +
      {{(PW-1){1'b0}}, fall_through_mode_reg & out_valid_next};
    full_next = count_next == `DCFF_DEPTH_STD ||
      (mark_valid_next && (wptr_next - mark_ptr_next) == `DCFF_DEPTH_STD);
    lvl_now = level_flags(total, depth, pae_ofs_reg, paf_ofs_reg);
    lvl_next = level_flags(total_next, depth, pae_ofs_reg, paf_ofs_reg);
    // sync timing lags the count by one edge; async follows the edge
    // that moved the count, so a write sets almost full and a read sets almost empty
    lvl_sel = sync_flags_reg ? lvl_now : lvl_next;
    flags_next.almost_empty_n = lvl_sel[1];
    flags_next.almost_full_n = lvl_sel[0];
    // empty goes high again once replay setup is over
    flags_next.empty_flag_n = fall_through_mode_reg ? 1'b1 :
      (state_next == dcff_pkg::DCFF_RUN && count_next != `DCFF_ZERO);
    flags_next.out_ready_n = fall_through_mode_reg ?
      !(out_valid_next && state_next == dcff_pkg::DCFF_RUN) : 1'b1;
    flags_next.full_flag_n = fall_through_mode_reg ? 1'b1 : !full_next;
    flags_next.in_ready_n = fall_through_mode_reg ? full_next : 1'b1;
    if (!cap_done_reg) begin
      flags_next = `DCFF_FLAGS_RST;
    end
  end

  // apb read data is fetched in the setup cycle for zero-wait access
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `DCFF_OFS_CTRL: prdata_next = {30'h0, ctrl_reg};
        `DCFF_OFS_PAE: prdata_next = {12'h000, pae_ofs_reg};
        `DCFF_OFS_PAF: prdata_next = {12'h000, paf_ofs_reg};
        `DCFF_OFS_STATUS: prdata_next = {21'h000000, async_rd_eff,
          sync_flags_reg, fall_through_mode_reg,
          state_reg == dcff_pkg::DCFF_REPLAY, mark_valid_reg, flags_reg};
        `DCFF_OFS_LEVEL: prdata_next = {12'h000, total};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= `DCFF_ZERO;
      rptr_reg <= `DCFF_ZERO;
      mark_ptr_reg <= `DCFF_ZERO;
      mark_valid_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      state_reg <= dcff_pkg::DCFF_RUN;
      sync_flags_reg <= 1'b0;
      fall_through_mode_reg <= 1'b0;
      cap_done_reg <= 1'b0;
      wen_prev_reg <= 1'b1;
      ren_prev_reg <= 1'b1;
      rt_prev_reg <= 1'b1;
      ctrl_reg <= 2'h0;
      pae_ofs_reg <= `DCFF_PAE_RST;
      paf_ofs_reg <= `DCFF_PAF_RST;
      flags_reg <= `DCFF_FLAGS_RST;
      prdata_reg <= 32'h00000000;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      mark_ptr_reg <= mark_ptr_next;
      mark_valid_reg <= mark_valid_next;
      out_valid_reg <= out_valid_next;
      state_reg <= state_next;
      sync_flags_reg <= sync_flags_next;
      fall_through_mode_reg <= fall_through_mode_next;
      cap_done_reg <= cap_done_next;
      wen_prev_reg <= write_enable_n;
      ren_prev_reg <= read_enable_n;
      rt_prev_reg <= replay_request_n;
      ctrl_reg <= ctrl_next;
      pae_ofs_reg <= pae_ofs_next;
      paf_ofs_reg <= paf_ofs_next;
      flags_reg <= flags_next;
      prdata_reg <= prdata_next;
    end
  end

  dcff_ram u_ram (
    .clk(pclk),
    .we(do_write),
    .waddr(wptr_reg[`DCFF_AW-1:0]),
    .wdata(wr_data),
    .re(ram_re),
    .raddr(rptr_reg[`DCFF_AW-1:0]),
    .q(rd_data)
  );

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign flags = flags_reg;
endmodule // dcff_top

// [verification/dcff_checker.sv]
// assertions on flag timing and replay of the fifo
`timescale 1ns/1ps
module dcff_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic write_enable_n,
  input wire logic write_select_n,
  input wire logic read_enable_n,
  input wire logic read_select_n,
  input wire logic replay_request_n,
  input wire logic fall_through_mode,
  input wire logic flag_timing_select,
  input wire dcff_pkg::dcff_flags_type flags
);
  logic wr, rd, st, ae, af;
  assign wr = !write_select_n && !write_enable_n;
  assign rd = !read_select_n && !read_enable_n;
  assign st = flag_timing_select;
  assign ae = flags.almost_empty_n;
  assign af = flags.almost_full_n;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the bench only replays with a mark set, so no mark tracking here
  a_replay_empty: assert property (
    $fell(replay_request_n) && !fall_through_mode
    |-> ##[1:2] !flags.empty_flag_n ##[1:2] flags.empty_flag_n)
    else $error("replay did not pulse empty");
  a_empty_hold: assert property (
    !flags.empty_flag_n && !wr && replay_request_n && !fall_through_mode
    |=> !flags.empty_flag_n)
    else $error("empty released without write");
  a_af_async_set: assert property (
    $fell(af) && !st |-> $past(wr))
    else $error("async almost full set without write");
  a_af_async_clr: assert property (
    $rose(af) && !st |-> $past(rd))
    else $error("async almost full cleared without read");
  a_ae_async_set: assert property (
    $fell(ae) && !st |-> $past(rd))
    else $error("async almost empty set without read");
  a_ae_async_clr: assert property (
    $rose(ae) && !st |-> $past(wr) || !$past(replay_request_n))
    else $error("async almost empty cleared without write");
  a_af_sync_set: assert property (
    $fell(af) && st |-> $past(wr, 2))
    else $error("sync almost full set off its write");
  a_af_sync_clr: assert property (
    $rose(af) && st |-> $past(rd, 2))
    else $error("sync almost full release off its read");
  a_ae_sync_clr: assert property (
    $rose(ae) && st |-> $past(wr, 2))
    else $error("sync almost empty release off its write");
  c_replay: cover property ($fell(replay_request_n));
  c_af: cover property ($fell(af));
  c_ae: cover property ($rose(ae));
endmodule // dcff_checker
bind dcff_top dcff_checker dcff_checker_i (.pclk(pclk), .presetn(presetn),
  .write_enable_n(write_enable_n), .write_select_n(write_select_n),
  .read_enable_n(read_enable_n), .read_select_n(read_select_n),
  .replay_request_n(replay_request_n), .fall_through_mode(fall_through_mode),
  .flag_timing_select(flag_timing_select), .flags(flags));

// [verification/dcff_partner.sv]
// writer and reader on the far side of the fifo data ports
`timescale 1ns/1ps
`include "dcff_params.svh"
module dcff_partner (
  input wire logic pclk,
  input wire logic [`DCFF_DATA_W-1:0] rd_data,
  output logic [`DCFF_DATA_W-1:0] wr_data,
  output logic write_enable_n,
  output logic write_select_n,
  output logic read_enable_n,
  output logic read_select_n,
  output logic replay_request_n
);
  initial begin
    wr_data = 36'h0;
    {write_enable_n, write_select_n} = 2'b11;
    {read_enable_n, read_select_n} = 2'b11;
    replay_request_n = 1'b1;
  end
  task automatic push(input logic [`DCFF_DATA_W-1:0] d);
    @(posedge pclk);
    wr_data <= d;
    {write_enable_n, write_select_n} <= 2'b00;
    @(posedge pclk);
    // idle bus shows the complement so stale data cannot pass
    wr_data <= ~d;
    {write_enable_n, write_select_n} <= 2'b11;
  endtask
  // enable held low over two edges: an edge-strobed port takes one word
  task automatic push_hold(input logic [`DCFF_DATA_W-1:0] d);
    @(posedge pclk);
    wr_data <= d;
    {write_enable_n, write_select_n} <= 2'b00;
    repeat (2) @(posedge pclk);
    wr_data <= ~d;
    {write_enable_n, write_select_n} <= 2'b11;
  endtask
  // two same-depth devices side by side; flags meet only through gates
  function automatic dcff_pkg::dcff_flags_type merge_flags(input logic ft,
      input dcff_pkg::dcff_flags_type a, input dcff_pkg::dcff_flags_type b);
    return ft ? (a | b) : (a & b);
  endfunction
  task automatic pop(output logic [`DCFF_DATA_W-1:0] d);
    @(posedge pclk);
    {read_enable_n, read_select_n} <= 2'b00;
    @(posedge pclk);
    {read_enable_n, read_select_n} <= 2'b11;
    #1;
    d = rd_data;
  endtask
  task automatic replay();
    @(posedge pclk);
    replay_request_n <= 1'b0;
    repeat (5) @(posedge pclk);
    replay_request_n <= 1'b1;
  endtask
endmodule // dcff_partner

// [verification/testbench.sv]
// self-checking bench for the flag and replay fifo
`timescale 1ns/1ps
`include "dcff_params.svh"
module testbench;
  localparam logic [35:0] BASE = 36'h5a5000000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [35:0] wd, rd_data;
  logic we_n, ws_n, re_n, rs_n, rr_n, ftm, fts;
  dcff_pkg::dcff_flags_type flags;
  int failures, cmp_count;
  dcff_top dcff_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wr_data(wd),
    .write_enable_n(we_n), .write_select_n(ws_n), .read_enable_n(re_n),
    .read_select_n(rs_n), .rd_data(rd_data), .replay_request_n(rr_n),
    .fall_through_mode(ftm), .flag_timing_select(fts), .flags(flags));
  dcff_partner dcff_partner_i (.pclk(pclk), .rd_data(rd_data),
    .wr_data(wd), .write_enable_n(we_n), .write_select_n(ws_n),
    .read_enable_n(re_n), .read_select_n(rs_n), .replay_request_n(rr_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic reset_dut(input logic f, input logic t);
    @(posedge pclk);
    {presetn, ftm, fts} <= {1'b0, f, t};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(1'b0, `DCFF_OFS_STATUS, 32'h0);
    chk({rv[10:4], rv[1:0]}, 36'h005);
    apb(1'b1, 8'h40, 32'hffffffff);
    chk(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rv}, 36'h100000000);
    $display("register test done");
  endtask
  task automatic t_async();
    logic [35:0] d;
    apb(1'b1, `DCFF_OFS_CTRL, 32'h3);
    apb(1'b0, `DCFF_OFS_STATUS, 32'h0);
    chk(rv[10], 1'b1);
    apb(1'b1, `DCFF_OFS_PAE, 32'h2);
    apb(1'b1, `DCFF_OFS_PAF, 32'h7fffc);
    for (int i = 1; i <= 4; i++) begin
      dcff_partner_i.push(BASE + 36'(i));
      settle(2);
      chk(flags.almost_empty_n, i > 2);
      chk(flags.almost_full_n, i < 4);
    end
    dcff_partner_i.push_hold(BASE + 36'h5);
    apb(1'b0, `DCFF_OFS_LEVEL, 32'h0);
    chk(rv, 36'h5);
    for (int i = 1; i <= 5; i++) begin
      dcff_partner_i.pop(d);
      chk(d, BASE + 36'(i));
    end
    settle(2);
    chk(flags.empty_flag_n, 1'b0);
    $display("async flag test done");
  endtask
  task automatic t_replay();
    logic [35:0] d;
    for (int i = 0; i < 70; i++) dcff_partner_i.push(BASE + 36'(i));
    for (int i = 0; i < 8; i++) begin
      if (i == 3) apb(1'b1, `DCFF_OFS_CTRL, 32'h4);
      dcff_partner_i.pop(d);
      chk(d, BASE + 36'(i));
    end
    dcff_partner_i.replay();
    settle(3);
    chk(flags.empty_flag_n, 1'b1);
    dcff_partner_i.pop(d);
    chk(d, BASE + 36'h3);
    apb(1'b0, `DCFF_OFS_LEVEL, 32'h0);
    chk(rv, 36'h42);
    $display("replay test done");
  endtask
  task automatic t_ft();
    logic [35:0] d;
    apb(1'b1, `DCFF_OFS_CTRL, 32'h2);
    apb(1'b0, `DCFF_OFS_STATUS, 32'h0);
    chk(rv[10:8], 36'h3);
    apb(1'b1, `DCFF_OFS_PAE, 32'h1);
    apb(1'b1, `DCFF_OFS_PAF, 32'h7fffc);
    for (int i = 0; i < 5; i++) begin
      dcff_partner_i.push(BASE + 36'(i));
      settle(3);
      chk(flags.almost_full_n, i < 4);
      chk(flags.almost_empty_n, i > 0);
    end
    chk(flags.out_ready_n, 1'b0);
    chk(rd_data, BASE);
    chk(dcff_partner_i.merge_flags(1'b1, flags, flags), 36'h32);
    dcff_partner_i.pop(d);
    chk(d, BASE + 36'h1);
    settle(3);
    chk(flags.almost_full_n, 1'b1);
    $display("fall-through test done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {ftm, fts} = 2'b00;
    failures = 0;
    cmp_count = 0;
    reset_dut(1'b0, 1'b0);
    t_regs();
    t_async();
    reset_dut(1'b0, 1'b0);
    t_replay();
    reset_dut(1'b1, 1'b1);
    t_ft();
    tally_and_finish();
  end
  initial begin
    #200000;
    failures++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule // testbench
